// ### logic/fbpi_top.sv
// Process image packing, system status and explicit service decoder.
// Assumes APB master on ref_clk; field pins asynchronous to ref_clk;
// the sensor-link agent answers with a one-cycle done pulse.
//
// Function
// - Read-one at class only; instance read-one and read-all return error status.
// - Service 4B at instance reads a link parameter, returned unchanged.
// - Service 4C at instance writes raw bytes into sensor-link device.
// - Class revision attribute 1 reads as one.
// - Class attribute 6 reads as seven.
// - No instance attributes are implemented.
// - Port layout: each port two bits, pin 4 low, pin 2 high.
// - Pin layout: byte 0 pin 4 of ports, byte 1 pin 2.
// - Same layout applies to both qualifiers and output image.
// - Input qualifier bit is one when its input is valid.
// - Status bit 0 shows bus/sensor supply undervoltage.
// - Status bit 1 shows actuator supply undervoltage.
// - Status bit 2 shows actuator supply absent.
// - Status bit 4 is OR of channel sensor shorts.
// - Status bit 5 is OR of channel actuator shorts.
// - Status bit 9 shows sensor-link errors except broken wire.
// - Status bit 10 shows bus/sensor supply overvoltage.
// - Status bit 11 shows actuator supply overvoltage.
// - Status bit 12 shows a sensor-link broken wire.
`include "fbpi_params.svh"
`default_nettype none
module fbpi_top #(
  parameter int NPORT = 8
) (
  input  wire logic              ref_clk,
  input  wire logic              reset,
  input  wire logic [11:0]       paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  input  wire logic [NPORT-1:0]  di_pin4,
  input  wire logic [NPORT-1:0]  di_pin2,
  input  wire logic [NPORT-1:0]  div_pin4,
  input  wire logic [NPORT-1:0]  div_pin2,
  output var  logic [NPORT-1:0]  do_pin4,
  output var  logic [NPORT-1:0]  do_pin2,
  output var  logic [NPORT-1:0]  doq_pin4,
  output var  logic [NPORT-1:0]  doq_pin2,
  input  wire logic [6:0]        fault_in,
  input  wire logic [NPORT-1:0]  link_err,
  input  wire logic [NPORT-1:0]  link_wire_brk,
  output var  logic              indexed_param_read,
  output var  logic              indexed_param_write,
  output var  logic [15:0]       param_index,
  output var  logic [7:0]        param_subindex,
  output var  logic [31:0]       param_wdata,
  input  wire logic              param_done,
  input  wire logic [31:0]       param_rdata
);
  // fault_in: 0 uv bus, 1 uv act, 2 no act, 3 ov bus, 4 ov act,
  // 5 any sensor short, 6 any actuator short (raw OR per kind).

  // --------------------------------------------------------------------
  // Layout function
  // --------------------------------------------------------------------
  function automatic logic [15:0] pack_img(input logic pinb,
                                           input logic [7:0] p4,
                                           input logic [7:0] p2);
    logic [15:0] v;
    v = 16'h0000;
    for (int i = 0; i < 8; i++) begin
      if (pinb) begin
        v[i]     = p4[i];
        v[i + 8] = p2[i];
      end else begin
        v[2 * i]     = p4[i];
        v[2 * i + 1] = p2[i];
      end
    end
    return v;
  endfunction

  // --------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------
  localparam int SW = 4 * NPORT + 7 + 2 * NPORT;
  logic [SW-1:0] sync1_r;
  logic [SW-1:0] sync2_r;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {di_pin4, di_pin2, div_pin4, div_pin2, fault_in,
                  link_err, link_wire_brk};
      sync2_r <= sync1_r;
    end
  end
  logic [NPORT-1:0] s_di4, s_di2, s_dv4, s_dv2, s_lerr, s_brk;
  logic [6:0]       s_flt;
  assign {s_di4, s_di2, s_dv4, s_dv2, s_flt, s_lerr, s_brk} = sync2_r;

  // --------------------------------------------------------------------
  // Control, images and status
  // --------------------------------------------------------------------
  logic        pinb_r;
  logic [15:0] do_img_r;
  logic [15:0] doq_img_r;
  logic [15:0] di_img_r;
  logic [15:0] diq_img_r;
  logic [31:0] sys_stat_r;
  logic [31:0] stat_nxt;
  logic        wr_acc;
  logic        rd_acc;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pinb_r    <= 1'b0;
      do_img_r  <= 16'h0000;
      doq_img_r <= 16'h0000;
    end else if (wr_acc) begin
      if (paddr == `FBPI_ADDR_CTRL)
        pinb_r <= pwdata[`FBPI_CTRL_PINBASED];
      if (paddr == `FBPI_ADDR_DO_IMG)
        do_img_r <= pwdata[15:0];
      if (paddr == `FBPI_ADDR_DOQ_IMG)
        doq_img_r <= pwdata[15:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      di_img_r  <= 16'h0000;
      diq_img_r <= 16'h0000;
    end else begin
      di_img_r  <= pack_img(pinb_r, s_di4, s_di2);
      diq_img_r <= pack_img(pinb_r, s_dv4, s_dv2);
    end
  end

  // Output images unpack with the same layout as inputs.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      do_pin4  <= '0;
      do_pin2  <= '0;
      doq_pin4 <= '0;
      doq_pin2 <= '0;
    end else begin
      for (int i = 0; i < 8; i++) begin
        do_pin4[i]  <= pinb_r ? do_img_r[i] : do_img_r[2 * i];
        do_pin2[i]  <= pinb_r ? do_img_r[i + 8] : do_img_r[2 * i + 1];
        doq_pin4[i] <= pinb_r ? doq_img_r[i] : doq_img_r[2 * i];
        doq_pin2[i] <= pinb_r ? doq_img_r[i + 8] : doq_img_r[2 * i + 1];
      end
    end
  end

  always_comb begin
    stat_nxt = 32'h0000_0000;
    stat_nxt[`FBPI_ST_UV_BUS]    = s_flt[0];
    stat_nxt[`FBPI_ST_UV_ACT]    = s_flt[1];
    stat_nxt[`FBPI_ST_NO_ACT]    = s_flt[2];
    stat_nxt[`FBPI_ST_OV_BUS]    = s_flt[3];
    stat_nxt[`FBPI_ST_OV_ACT]    = s_flt[4];
    stat_nxt[`FBPI_ST_SEN_SHORT] = s_flt[5];
    stat_nxt[`FBPI_ST_ACT_SHORT] = s_flt[6];
    stat_nxt[`FBPI_ST_LINK_ERR]  = |(s_lerr & ~s_brk);
    stat_nxt[`FBPI_ST_WIRE_BRK]  = |s_brk;
  end

  always_ff @(posedge ref_clk) begin
    if (reset)
      sys_stat_r <= 32'h0000_0000;
    else
      sys_stat_r <= stat_nxt;
  end

  // --------------------------------------------------------------------
  // Service decoder
  // --------------------------------------------------------------------
  fbpi_pkg::fbpi_req_t   req;
  fbpi_pkg::fbpi_state_t state_r;
  logic [1:0]            svc_st_r;
  logic [31:0]           svc_data_r;
  logic [23:0]           svc_arg_r;
  logic                  go;
  logic                  rd_kind_r;
  assign req = fbpi_pkg::fbpi_req_t'(pwdata[16:0]);
  assign go  = wr_acc && paddr == `FBPI_ADDR_SVC_REQ &&
               state_r == fbpi_pkg::FBPI_IDLE;

  always_ff @(posedge ref_clk) begin
    if (reset)
      svc_arg_r <= 24'h000000;
    else if (wr_acc && paddr == `FBPI_ADDR_SVC_ARG &&
             state_r == fbpi_pkg::FBPI_IDLE)
      svc_arg_r <= pwdata[23:0];
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_r             <= fbpi_pkg::FBPI_IDLE;
      svc_st_r            <= 2'h0;
      svc_data_r          <= 32'h0000_0000;
      indexed_param_read  <= 1'b0;
      indexed_param_write <= 1'b0;
      param_index         <= 16'h0000;
      param_subindex      <= 8'h00;
      param_wdata         <= 32'h0000_0000;
    end else begin
      unique case (state_r)
        fbpi_pkg::FBPI_IDLE: begin
          if (go) begin
            svc_st_r   <= `FBPI_ST_OK;
            svc_data_r <= 32'h0000_0000;
            if (!req.inst && req.code == `FBPI_SVC_GET_ONE) begin
              unique case (req.attr)
                `FBPI_ATTR_REV:
                  svc_data_r <= 32'(`FBPI_VAL_REV);
                `FBPI_ATTR_MAX_INST:
                  svc_data_r <= 32'(`FBPI_VAL_MAX_INST);
                `FBPI_ATTR_MAX_CATTR:
                  svc_data_r <= 32'(`FBPI_VAL_MAX_CATTR);
                `FBPI_ATTR_MAX_IATTR:
                  svc_data_r <= 32'(`FBPI_VAL_MAX_IATTR);
                default:
                  svc_st_r   <= `FBPI_ST_ERR;
              endcase
            end else if (req.inst && req.code == `FBPI_SVC_PRM_READ) begin
              indexed_param_read <= 1'b1;
              param_index        <= svc_arg_r[23:8];
              param_subindex     <= svc_arg_r[7:0];
              state_r            <= fbpi_pkg::FBPI_LINK;
              svc_st_r           <= 2'h0;
            end else if (req.inst && req.code == `FBPI_SVC_PRM_WRITE) begin
              indexed_param_write <= 1'b1;
              param_index         <= svc_arg_r[23:8];
              param_subindex      <= svc_arg_r[7:0];
              param_wdata         <= svc_data_r;
              state_r             <= fbpi_pkg::FBPI_LINK;
              svc_st_r            <= 2'h0;
            end else begin
              svc_st_r <= `FBPI_ST_ERR;
            end
          end else if (wr_acc && paddr == `FBPI_ADDR_SVC_DATA) begin
            svc_data_r <= pwdata;
          end
        end
        fbpi_pkg::FBPI_LINK: begin
          indexed_param_read  <= 1'b0;
          indexed_param_write <= 1'b0;
          if (param_done) begin
            if (indexed_param_read)
              svc_data_r <= svc_data_r;
            svc_st_r <= `FBPI_ST_OK;
            state_r  <= fbpi_pkg::FBPI_DONE;
          end
        end
        fbpi_pkg::FBPI_DONE: begin
          state_r <= fbpi_pkg::FBPI_IDLE;
        end
        default: state_r <= fbpi_pkg::FBPI_IDLE;
      endcase
      if (state_r == fbpi_pkg::FBPI_LINK && param_done && rd_kind_r)
        svc_data_r <= param_rdata;
    end
  end

  // Remembers whether the outstanding link job is a read.
  always_ff @(posedge ref_clk) begin
    if (reset)
      rd_kind_r <= 1'b0;
    else if (go)
      rd_kind_r <= req.inst && req.code == `FBPI_SVC_PRM_READ;
  end

  // --------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable) begin
        unique case (paddr)
          `FBPI_ADDR_CTRL:     prdata <= {31'h0, pinb_r};
          `FBPI_ADDR_DI_IMG:   prdata <= {16'h0, di_img_r};
          `FBPI_ADDR_DIQ_IMG:  prdata <= {16'h0, diq_img_r};
          `FBPI_ADDR_DO_IMG:   prdata <= {16'h0, do_img_r};
          `FBPI_ADDR_DOQ_IMG:  prdata <= {16'h0, doq_img_r};
          `FBPI_ADDR_SYS_STAT: prdata <= sys_stat_r;
          `FBPI_ADDR_SVC_REQ:  prdata <= 32'h0000_0000;
          `FBPI_ADDR_SVC_ARG:  prdata <= {8'h0, svc_arg_r};
          `FBPI_ADDR_SVC_RSP:
            prdata <= {29'h0, state_r != fbpi_pkg::FBPI_IDLE, svc_st_r};
          `FBPI_ADDR_SVC_DATA: prdata <= svc_data_r;
          default:             pslverr <= 1'b1;
        endcase
      end
    end
  end
endmodule // fbpi_top
`default_nettype wire

// ### logic/fbpi_params.svh
// Constants for the fieldbus process image block.
// Assumes inclusion by bare name from the design file.
`ifndef FBPI_PARAMS_SVH
`define FBPI_PARAMS_SVH
// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define FBPI_ADDR_CTRL      12'h000
`define FBPI_ADDR_DI_IMG    12'h004
`define FBPI_ADDR_DIQ_IMG   12'h008
`define FBPI_ADDR_DO_IMG    12'h00c
`define FBPI_ADDR_DOQ_IMG   12'h010
`define FBPI_ADDR_SYS_STAT  12'h014
`define FBPI_ADDR_SVC_REQ   12'h018
`define FBPI_ADDR_SVC_ARG   12'h01c
`define FBPI_ADDR_SVC_RSP   12'h020
`define FBPI_ADDR_SVC_DATA  12'h024
// ----------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------
`define FBPI_CTRL_PINBASED  0
`define FBPI_REQ_GO_BIT     16
`define FBPI_REQ_INST_BIT   8
`define FBPI_ST_UV_BUS      0
`define FBPI_ST_UV_ACT      1
`define FBPI_ST_NO_ACT      2
`define FBPI_ST_SEN_SHORT   4
`define FBPI_ST_ACT_SHORT   5
`define FBPI_ST_LINK_ERR    9
`define FBPI_ST_OV_BUS      10
`define FBPI_ST_OV_ACT      11
`define FBPI_ST_WIRE_BRK    12
// ----------------------------------------------------------------------
// Service codes and values
// ----------------------------------------------------------------------
`define FBPI_SVC_GET_ALL    8'h01
`define FBPI_SVC_GET_ONE    8'h0e
`define FBPI_SVC_SET_ONE    8'h4c
`define FBPI_SVC_PRM_READ   8'h4b
`define FBPI_SVC_PRM_WRITE  8'h4c
`define FBPI_ATTR_REV       8'h01
`define FBPI_ATTR_MAX_INST  8'h02
`define FBPI_ATTR_MAX_CATTR 8'h06
`define FBPI_ATTR_MAX_IATTR 8'h07
`define FBPI_VAL_REV        16'h0001
`define FBPI_VAL_MAX_INST   16'h0001
`define FBPI_VAL_MAX_CATTR  16'h0007
`define FBPI_VAL_MAX_IATTR  16'h0000
`define FBPI_ST_OK          2'h1
`define FBPI_ST_ERR         2'h2
`endif

// ### logic/fbpi_pkg.sv
// Types for the fieldbus process image block.
// Assumes fbpi_params.svh is on the include path.
`default_nettype none
package fbpi_pkg;
  typedef struct packed {
    logic       inst;
    logic [7:0] code;
    logic [7:0] attr;
  } fbpi_req_t;
  typedef struct packed {
    logic [1:0]  status;
    logic        busy;
    logic        prm_wr;
    logic        prm_rd;
    logic [15:0] index;
    logic [7:0]  subindex;
  } fbpi_rsp_t;
  typedef enum logic [1:0] {FBPI_IDLE, FBPI_LINK, FBPI_DONE} fbpi_state_t;
endpackage
`default_nettype wire

// ### bench/fbpi_top_assertions.sv
// Concurrent checks on the fieldbus process image block.
// Assumes it is bound to fbpi_top and sees only its ports.
`default_nettype none
module fbpi_chk #(
  parameter int NPORT = 8
) (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        indexed_param_read,
  input wire logic        indexed_param_write,
  input wire logic [15:0] param_index,
  input wire logic [7:0]  param_subindex,
  input wire logic [31:0] param_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic        setup;
  logic        acc_w;
  logic        go;
  logic        rd_req_r;
  logic        wr_req_r;
  logic        st_rd_r;
  logic [31:0] arg_r;
  logic [31:0] dat_r;
  assign setup = psel && !penable;
  assign acc_w = psel && penable && pwrite;
  assign go = indexed_param_read || indexed_param_write;
  always_ff @(posedge ref_clk) begin
    rd_req_r <= acc_w && paddr == 12'h018 && pwdata[16:8] == 9'h14b;
    wr_req_r <= acc_w && paddr == 12'h018 && pwdata[16:8] == 9'h14c;
    st_rd_r  <= setup && !pwrite && paddr == 12'h014;
    if (acc_w && paddr == 12'h01c) arg_r <= pwdata;
    if (acc_w && paddr == 12'h024) dat_r <= pwdata;
  end
  sequence cls_req;
    acc_w && paddr == 12'h018 && !pwdata[16];
  endsequence
  sequence no_pulse;
    !indexed_param_read && !indexed_param_write;
  endsequence
  apb_answer_a: assert property (setup |=> pready)
    else $error("pready missing after setup");
  apb_single_a: assert property (pready |-> $past(setup))
    else $error("pready without setup");
  addr_err_a: assert property (setup && (paddr[1:0] != 2'h0 ||
    paddr > 12'h024) |=> pslverr) else $error("unmapped not refused");
  addr_ok_a: assert property (setup && paddr[1:0] == 2'h0 &&
    paddr <= 12'h024 |=> !pslverr) else $error("mapped refused");
  class_nolink_a: assert property (cls_req |=> no_pulse)
    else $error("class request reached link");
  rd_cause_a: assert property (indexed_param_read |-> rd_req_r)
    else $error("read pulse without request");
  wr_cause_a: assert property (indexed_param_write |-> wr_req_r)
    else $error("write pulse without request");
  pulse_once_a: assert property (go |=> no_pulse)
    else $error("link pulse too long");
  index_source_a: assert property (go |-> param_index == arg_r[23:8]
    && param_subindex == arg_r[7:0]) else $error("index mismatch");
  index_hold_a: assert property (go |=> ($stable(param_index) &&
    $stable(param_subindex))[*3]) else $error("index not held");
  wdata_source_a: assert property (indexed_param_write |->
    param_wdata == dat_r) else $error("write data mismatch");
  stat_zero_a: assert property (st_rd_r && pready |->
    prdata[31:13] == 19'h0 && prdata[8:6] == 3'h0 && !prdata[3])
    else $error("reserved status bit set");
endmodule // fbpi_chk
bind fbpi_top fbpi_chk #(.NPORT(NPORT)) u_chk (.ref_clk, .reset, .paddr,
  .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
  .indexed_param_read, .indexed_param_write, .param_index,
  .param_subindex, .param_wdata);
`default_nettype wire

// ### bench/fbpi_link_agent.sv
// Model of the sensor-link agent that serves parameter requests.
// Assumes the request pulses and index lines of fbpi_top on ref_clk.
`default_nettype none
module fbpi_link_agent (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        rd,
  input  wire logic        wr,
  input  wire logic [15:0] idx,
  input  wire logic [7:0]  sub,
  input  wire logic [3:0]  dly,
  output var  logic        done,
  output var  logic [31:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        act_r;
  logic [3:0]  cnt_r;
  logic [31:0] val_r;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      act_r <= 1'h0;
      done  <= 1'h0;
    end else begin
      done <= 1'h0;
      if (rd || wr) begin
        act_r <= 1'h1;
        cnt_r <= dly;
        val_r <= {idx, sub, 8'h5a};
      end else if (act_r && cnt_r == 4'h0) begin
        act_r <= 1'h0;
        done  <= 1'h1;
      end else if (act_r) begin
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end
  assign rdata = done ? val_r : ~val_r;
endmodule // fbpi_link_agent
`default_nettype wire

// ### bench/fbpi_top_tb.sv
// Self-checking bench for the fieldbus process image block.
// Assumes fbpi_top, fbpi_link_agent and the bound checker are compiled.
`default_nettype none
module fbpi_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, reset, psel, penable, pwrite, pready, pslverr;
  logic        indexed_param_read, indexed_param_write, param_done, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, param_wdata, param_rdata, q, cap_wd;
  logic [7:0]  di_pin4, di_pin2, div_pin4, div_pin2, do_pin4, do_pin2;
  logic [7:0]  doq_pin4, doq_pin2, link_err, link_wire_brk, param_subindex;
  logic [6:0]  fault_in;
  logic [15:0] param_index;
  logic [23:0] cap_ix;
  logic [3:0]  dly;
  int          n_mismatch, samples_checked, cyc, n_pulse;
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  n_mismatch++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
  fbpi_top #(.NPORT(8)) dut (.ref_clk, .reset, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .di_pin4, .di_pin2,
    .div_pin4, .div_pin2, .do_pin4, .do_pin2, .doq_pin4, .doq_pin2,
    .fault_in, .link_err, .link_wire_brk, .indexed_param_read,
    .indexed_param_write, .param_index, .param_subindex, .param_wdata,
    .param_done, .param_rdata);
  fbpi_link_agent u_agent (.ref_clk, .reset, .rd(indexed_param_read),
    .wr(indexed_param_write), .idx(param_index), .sub(param_subindex),
    .dly, .done(param_done), .rdata(param_rdata));
  initial begin
    ref_clk = 1'h0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (indexed_param_read === 1'h1 || indexed_param_write === 1'h1) begin
      n_pulse++;
      cap_ix = {param_index, param_subindex};
      cap_wd = param_wdata;
    end
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  task test_done;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // --------------------------------------------------------------------
  // Bus tasks
  // --------------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    psel    <= 1'h1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) n_mismatch++;
    q   = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge ref_clk);
  endtask
  task automatic svc(input logic [16:0] req, input logic [1:0] st);
    int n;
    apb(1'h1, 12'h018, {15'h0, req});
    n = 0;
    do begin
      apb(1'h0, 12'h020, 32'h0);
      n++;
    end while (q[2] !== 1'h0 && n < 30);
    `CHK("svc_idle", 1'h0, q[2])
    `CHK("svc_status", st, q[1:0])
  endtask
  function automatic logic [15:0] pack(input logic pin,
                                       input logic [7:0] p4, p2);
    logic [15:0] r;
    for (int k = 0; k < 8; k++) r[2*k+:2] = {p2[k], p4[k]};
    return pin ? {p2, p4} : r;
  endfunction
  task automatic st_chk(input logic [8:0] c, input logic [31:0] e);
    fault_in      <= c[6:0];
    link_err      <= {c[7], 6'h0, c[8]};
    link_wire_brk <= {7'h0, c[8]};
    repeat (4) @(posedge ref_clk);
    apb(1'h0, 12'h014, 32'h0);
    `CHK("sys_stat", e, q)
  endtask
  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_image;
    for (int pb = 0; pb < 2; pb++) begin
      apb(1'h1, 12'h000, {31'h0, pb[0]});
      repeat (4) @(posedge ref_clk);
      apb(1'h0, 12'h004, 32'h0);
      `CHK("di", pack(pb[0], di_pin4, di_pin2), q[15:0])
      apb(1'h0, 12'h008, 32'h0);
      `CHK("diq", pack(pb[0], div_pin4, div_pin2), q[15:0])
      apb(1'h1, 12'h00c, 32'h0000a5c3);
      apb(1'h1, 12'h010, 32'h00003c96);
      @(posedge ref_clk);
      `CHK("do", 16'ha5c3, pack(pb[0], do_pin4, do_pin2))
      `CHK("doq", 16'h3c96, pack(pb[0], doq_pin4, doq_pin2))
    end
  endtask
  task automatic t_class;
    apb(1'h0, 12'h030, 32'h0);
    `CHK("slverr", 1'h1, err)
    svc(17'h00e01, 2'h1);
    apb(1'h0, 12'h024, 32'h0);
    `CHK("revision", 32'h1, q)
    svc(17'h00e06, 2'h1);
    apb(1'h0, 12'h024, 32'h0);
    `CHK("max_attr", 32'h7, q)
    svc(17'h00e02, 2'h1);
    apb(1'h0, 12'h024, 32'h0);
    `CHK("max_inst", 32'h1, q)
    svc(17'h00e07, 2'h1);
    apb(1'h0, 12'h024, 32'h0);
    `CHK("max_iattr", 32'h0, q)
    svc(17'h00e03, 2'h2);
    svc(17'h00101, 2'h2);
    svc(17'h04c01, 2'h2);
    svc(17'h04b00, 2'h2);
    svc(17'h10e01, 2'h2);
    svc(17'h10101, 2'h2);
    svc(17'h17700, 2'h2);
    `CHK("no_link", 0, n_pulse)
  endtask
  task automatic t_param;
    apb(1'h1, 12'h01c, 32'h00123456);
    svc(17'h14b00, 2'h1);
    `CHK("rd_index", 24'h123456, cap_ix)
    apb(1'h0, 12'h024, 32'h0);
    `CHK("rd_data", 32'h1234565a, q)
    dly <= 4'h9;
    apb(1'h1, 12'h01c, 32'h00abcd07);
    apb(1'h1, 12'h024, 32'hdeadbeef);
    svc(17'h14c00, 2'h1);
    `CHK("wr_data", 32'hdeadbeef, cap_wd)
    `CHK("wr_index", 24'habcd07, cap_ix)
    `CHK("pulses", 2, n_pulse)
  endtask
  initial begin
    reset = 1'h1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {fault_in, link_err, link_wire_brk, dly} = '0;
    di_pin4  = 8'hc5;
    di_pin2  = 8'h3a;
    div_pin4 = 8'h96;
    div_pin2 = 8'h0f;
    repeat (16) @(posedge ref_clk);
    reset <= 1'h0;
    repeat (2) @(posedge ref_clk);
    t_image();
    st_chk(9'h001, 32'h00000001);
    st_chk(9'h002, 32'h00000002);
    st_chk(9'h004, 32'h00000004);
    st_chk(9'h020, 32'h00000010);
    st_chk(9'h040, 32'h00000020);
    st_chk(9'h080, 32'h00000200);
    st_chk(9'h008, 32'h00000400);
    st_chk(9'h010, 32'h00000800);
    st_chk(9'h100, 32'h00001000);
    st_chk(9'h1ff, 32'h00001e37);
    st_chk(9'h000, 32'h00000000);
    t_class();
    t_param();
    test_done();
  end
endmodule // fbpi_top_tb
`default_nettype wire
